/* hw/sav_top.sv */
// Containment pressure votes, safety injection and depressurization
// actuation for two independent trains, with an AXI4-Lite register port.
// Assumes all channel and switch inputs are asynchronous to aclk.
`timescale 1ns/100ps

module sav_top
    import sav_pkg::*;
#(
    parameter logic [31:0] RESET_DELAY_CYCLES = sav_pkg::SAV_RESET_DELAY_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire sav_pkg::sav_chan_in_t chan_in,
    input wire sav_pkg::sav_train_in_t [1:0] train_in,
    input wire logic [sav_pkg::SAV_WIDE_W-1:0] wide_range_press,
    output sav_pkg::sav_train_out_t [1:0] train_out,
    output logic [1:0] tank_alarm,
    output logic recirc_changeover,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import sav_pkg::*;

    localparam int CW = $bits(sav_chan_in_t);
    localparam int TW = $bits(sav_train_in_t);
    localparam int SW = CW + 2 * TW + SAV_WIDE_W;
    localparam logic [SW-1:0] SYNC_RST =
        {SAV_CHAN_IDLE, {(2 * TW){1'b0}}, {SAV_WIDE_W{1'b0}}};

    sav_state_t q_ff;
    sav_state_t nxt_q;

    sav_chan_in_t s_chan;
    sav_train_in_t [1:0] s_train;
    logic [SAV_WIDE_W-1:0] s_wide;
    logic [SW-1:0] sync_out;

    logic [1:0] hi_vote;
    logic [1:0] ihh_vote;
    logic [1:0] hh_vote;
    logic [1:0] si_auto;
    logic [1:0] changeover_vote;

    generate
        if (RESET_DELAY_CYCLES == 32'h0) begin : g_chk
            $error("RESET_DELAY_CYCLES must be at least one.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    // Every pin passes two flops before any vote reads it.
    sav_sync #(
        .W(SW),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({chan_in, train_in, wide_range_press}),
        .dout(sync_out)
    );

    assign {s_chan, s_train, s_wide} = sync_out;

    ////////////////////////////////////////////////////////////////////////

    // Each train has its own copy of the coincidence logic.
    generate
        for (genvar t = 0; t < SAV_TRAINS; t++) begin : g_train
            logic hi_meas;
            logic hi_test;
            logic ihh_meas;
            logic ihh_test;
            logic flow_hi;
            logic press_lo;
            logic tavg_lo;

            sav_vote #(.N(3), .K(2)) u_hi_meas (
                .trip(~s_chan.hi_ok),
                .hit(hi_meas)
            );
            sav_vote #(.N(3), .K(2)) u_hi_test (
                .trip(~s_chan.hi_test_closed),
                .hit(hi_test)
            );
            sav_vote #(.N(3), .K(2)) u_ihh_meas (
                .trip(~s_chan.ihh_ok),
                .hit(ihh_meas)
            );
            sav_vote #(.N(3), .K(2)) u_ihh_test (
                .trip(~s_chan.ihh_test_closed),
                .hit(ihh_test)
            );
            sav_vote #(.N(4), .K(2)) u_hh (
                .trip(s_chan.hh_trip & s_chan.hh_test_closed),
                .hit(hh_vote[t])
            );
            sav_vote #(.N(3), .K(2)) u_flow (
                .trip(s_chan.steam_flow_hi),
                .hit(flow_hi)
            );
            sav_vote #(.N(3), .K(2)) u_press (
                .trip(s_chan.steam_press_lo),
                .hit(press_lo)
            );
            sav_vote #(.N(3), .K(2)) u_tavg (
                .trip(s_chan.tavg_lolo),
                .hit(tavg_lo)
            );
            sav_vote #(.N(4), .K(2)) u_tank (
                .trip(s_chan.tank_low),
                .hit(changeover_vote[t])
            );

            assign hi_vote[t] = hi_meas | hi_test;
            assign ihh_vote[t] = ihh_meas | ihh_test;
            assign si_auto[t] = (flow_hi & (press_lo | tavg_lo))
                | s_chan.steam_dp_hi | s_chan.prz_press_lolo
                | hi_vote[t];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [31:0] read_word(
        input logic [7:0] addr,
        input sav_state_t s,
        input logic [1:0] hv,
        input logic [1:0] iv,
        input logic [1:0] hhv,
        input logic [SAV_WIDE_W-1:0] wide
    );
        logic [31:0] w;
        w = 32'h0;
        case (addr)
            SAV_OFS_CTRL: begin
                w[5:0] = s.axi.force_bits;
            end
            SAV_OFS_STATUS: begin
                // Per-train byte: votes, master outputs, then the latches.
                for (int t = 0; t < SAV_TRAINS; t++) begin
                    w[t * SAV_STAT_TRAIN_W +: SAV_STAT_TRAIN_W] = {
                        s.train[t].cda_latch,
                        s.train[t].si_latch,
                        s.train[t].out.master_sli,
                        s.train[t].out.master_cda,
                        s.train[t].out.master_si,
                        hhv[t],
                        iv[t],
                        hv[t]};
                end
                w[SAV_STAT_TANK_POS +: 2] = s.tank_alarm;
                w[SAV_STAT_CHG_POS] = s.changeover;
            end
            SAV_OFS_WIDE: begin
                w[SAV_WIDE_W-1:0] = wide;
            end
            SAV_OFS_TIMER0: begin
                w = s.train[0].timer;
            end
            SAV_OFS_TIMER1: begin
                w = s.train[1].timer;
            end
            default: begin
                w = 32'h0;
            end
        endcase
        return w;
    endfunction

    function automatic logic addr_ok(input logic [7:0] addr);
        return addr == SAV_OFS_CTRL || addr == SAV_OFS_STATUS
            || addr == SAV_OFS_WIDE || addr == SAV_OFS_TIMER0
            || addr == SAV_OFS_TIMER1;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // Write address and data are taken together; reads wait for rvalid to clear.
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~q_ff.axi.bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = ~q_ff.axi.rvalid;

    always_comb begin
        logic cause_si;
        logic cause_cda;
        logic cause_sli;
        logic clear_si;
        logic clear_cda;
        logic si_on;
        logic cda_on;
        cause_si = 1'b0;
        cause_cda = 1'b0;
        cause_sli = 1'b0;
        clear_si = 1'b0;
        clear_cda = 1'b0;
        si_on = 1'b0;
        cda_on = 1'b0;
        nxt_q = q_ff;

        for (int t = 0; t < SAV_TRAINS; t++) begin
            cause_si = si_auto[t] | (|s_train[t].manual_si)
                | q_ff.axi.force_bits[t];
            cause_cda = hh_vote[t]
                | (&s_train[t].manual_spray)
                | q_ff.axi.force_bits[2 + t];
            cause_sli = ihh_vote[t] | s_train[t].manual_sli
                | q_ff.axi.force_bits[4 + t];

            // The delay restarts only when a new actuation begins.
            if (cause_si && !q_ff.train[t].si_latch) begin
                nxt_q.train[t].timer = RESET_DELAY_CYCLES;
            end else if (q_ff.train[t].timer != 32'h0) begin
                nxt_q.train[t].timer = q_ff.train[t].timer - 32'h1;
            end

            clear_si = q_ff.train[t].si_latch
                && q_ff.train[t].timer == 32'h0
                && s_train[t].si_selector_normal_or_clear
                && s_train[t].breakers_open;
            clear_cda = q_ff.train[t].cda_latch
                && s_train[t].spray_selector_normal_or_clear;

            // A cause present in the clearing cycle keeps the latch set.
            nxt_q.train[t].si_latch = cause_si
                | (q_ff.train[t].si_latch & ~clear_si);
            nxt_q.train[t].cda_latch = cause_cda
                | (q_ff.train[t].cda_latch & ~clear_cda);
            si_on = nxt_q.train[t].si_latch;
            cda_on = nxt_q.train[t].cda_latch;

            nxt_q.train[t].out.master_si = si_on;
            nxt_q.train[t].out.reactor_trip = si_on;
            nxt_q.train[t].out.injection = si_on;
            nxt_q.train[t].out.isol_phase_a = si_on;
            nxt_q.train[t].out.diesel_start = si_on;
            nxt_q.train[t].out.feed_iso = si_on;
            nxt_q.train[t].out.aux_feed_start = si_on;
            nxt_q.train[t].out.service_water = si_on;
            nxt_q.train[t].out.turbine_trip = si_on;
            nxt_q.train[t].out.master_cda = cda_on;
            nxt_q.train[t].out.quench_spray = cda_on;
            nxt_q.train[t].out.recirc_spray = cda_on;
            nxt_q.train[t].out.chem_add = cda_on;
            nxt_q.train[t].out.sw_valves = cda_on;
            nxt_q.train[t].out.diesel_load = cda_on;
            nxt_q.train[t].out.isol_phase_b = cda_on;
            nxt_q.train[t].out.master_sli = cause_sli;
            nxt_q.train[t].out.steam_iso = cause_sli;
        end

        nxt_q.tank_alarm = s_chan.tank_low[1:0];
        nxt_q.changeover = changeover_vote[0];

        // Register write: only the control word is writable.
        if (s_axi_awready) begin
            nxt_q.axi.bvalid = 1'b1;
            nxt_q.axi.awaddr = s_axi_awaddr;
            if (s_axi_awaddr == SAV_OFS_CTRL) begin
                nxt_q.axi.bresp = SAV_RESP_OKAY;
                if (s_axi_wstrb[0]) begin
                    nxt_q.axi.force_bits = s_axi_wdata[5:0];
                end
            end else if (addr_ok(s_axi_awaddr)) begin
                nxt_q.axi.bresp = SAV_RESP_OKAY;
            end else begin
                nxt_q.axi.bresp = SAV_RESP_SLVERR;
            end
        end else if (q_ff.axi.bvalid && s_axi_bready) begin
            nxt_q.axi.bvalid = 1'b0;
        end

        // Register read: data are captured at the address handshake.
        if (s_axi_arvalid && !q_ff.axi.rvalid) begin
            nxt_q.axi.rvalid = 1'b1;
            nxt_q.axi.rdata = read_word(s_axi_araddr, q_ff, hi_vote,
                ihh_vote, hh_vote, s_wide);
            nxt_q.axi.rresp = addr_ok(s_axi_araddr) ? SAV_RESP_OKAY
                : SAV_RESP_SLVERR;
        end else if (q_ff.axi.rvalid && s_axi_rready) begin
            nxt_q.axi.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign train_out = {q_ff.train[1].out, q_ff.train[0].out};
    assign tank_alarm = q_ff.tank_alarm;
    assign recirc_changeover = q_ff.changeover;
    assign s_axi_bvalid = q_ff.axi.bvalid;
    assign s_axi_bresp = q_ff.axi.bresp;
    assign s_axi_rvalid = q_ff.axi.rvalid;
    assign s_axi_rresp = q_ff.axi.rresp;
    assign s_axi_rdata = q_ff.axi.rdata;
endmodule

/* hw/sav_pkg.sv */
// Constants, carrier structs and state layout for the actuation voting block.
// Assumes a single 50 MHz clock and an AXI4-Lite master with 32-bit data.
package sav_pkg;

    localparam int SAV_TRAINS = 2;
    localparam longint unsigned SAV_CLK_HZ = 64'd50000000;
    localparam longint unsigned SAV_RESET_DELAY_MIN = 64'd1;
    localparam logic [31:0] SAV_RESET_DELAY_CYC =
        32'(SAV_RESET_DELAY_MIN * 64'd60 * SAV_CLK_HZ);
    localparam int SAV_WIDE_W = 12;

    localparam logic [7:0] SAV_OFS_CTRL = 8'h00;
    localparam logic [7:0] SAV_OFS_STATUS = 8'h04;
    localparam logic [7:0] SAV_OFS_WIDE = 8'h08;
    localparam logic [7:0] SAV_OFS_TIMER0 = 8'h0c;
    localparam logic [7:0] SAV_OFS_TIMER1 = 8'h10;
    localparam logic [5:0] SAV_CTRL_RST = 6'h00;
    localparam int SAV_STAT_TRAIN_W = 8;
    localparam int SAV_STAT_TANK_POS = 16;
    localparam int SAV_STAT_CHG_POS = 18;
    localparam logic [1:0] SAV_RESP_OKAY = 2'h0;
    localparam logic [1:0] SAV_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] hi_ok;
        logic [2:0] hi_test_closed;
        logic [2:0] ihh_ok;
        logic [2:0] ihh_test_closed;
        logic [3:0] hh_trip;
        logic [3:0] hh_test_closed;
        logic [2:0] steam_flow_hi;
        logic [2:0] steam_press_lo;
        logic [2:0] tavg_lolo;
        logic steam_dp_hi;
        logic prz_press_lolo;
        logic [3:0] tank_low;
    } sav_chan_in_t;

    localparam sav_chan_in_t SAV_CHAN_IDLE = '{
        hi_ok: 3'h7, hi_test_closed: 3'h7, ihh_ok: 3'h7,
        ihh_test_closed: 3'h7, hh_trip: 4'h0, hh_test_closed: 4'hf,
        steam_flow_hi: 3'h0, steam_press_lo: 3'h0, tavg_lolo: 3'h0,
        steam_dp_hi: 1'b0, prz_press_lolo: 1'b0, tank_low: 4'h0};

    typedef struct packed {
        logic [1:0] manual_si;
        logic [1:0] manual_spray;
        logic manual_sli;
        logic si_selector_normal_or_clear;
        logic spray_selector_normal_or_clear;
        logic breakers_open;
    } sav_train_in_t;

    typedef struct packed {
        logic master_si;
        logic reactor_trip;
        logic injection;
        logic isol_phase_a;
        logic diesel_start;
        logic feed_iso;
        logic aux_feed_start;
        logic service_water;
        logic turbine_trip;
        logic master_cda;
        logic quench_spray;
        logic recirc_spray;
        logic chem_add;
        logic sw_valves;
        logic diesel_load;
        logic isol_phase_b;
        logic master_sli;
        logic steam_iso;
    } sav_train_out_t;

    typedef struct packed {
        logic [5:0] force_bits;
        logic [7:0] awaddr;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } sav_axi_st_t;

    typedef struct packed {
        logic si_latch;
        logic cda_latch;
        logic [31:0] timer;
        sav_train_out_t out;
    } sav_train_st_t;

    typedef struct packed {
        sav_train_st_t [SAV_TRAINS-1:0] train;
        logic [1:0] tank_alarm;
        logic changeover;
        sav_axi_st_t axi;
    } sav_state_t;

endpackage

/* hw/sav_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; no word coherence is implied.
`timescale 1ns/100ps
module sav_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [1:0][W-1:0] q_ff;
    logic [1:0][W-1:0] nxt_q;

    generate
        if (W < 1) begin : g_chk
            $error("sav_sync width must be positive.");
        end
    endgenerate

    // The first stage is read only by the second stage.
    always_comb begin
        nxt_q[0] = din;
        nxt_q[1] = q_ff[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= {RST_VAL, RST_VAL};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign dout = q_ff[1];
endmodule

/* hw/sav_vote.sv */
// K-out-of-N coincidence vote over a vector of channel trips.
// Assumes synchronised inputs; the result is combinational.
`timescale 1ns/100ps
module sav_vote #(
    parameter int N = 3,
    parameter int K = 2
) (
    input wire logic [N-1:0] trip,
    output logic hit
);
    generate
        if (K < 1 || K > N) begin : g_chk
            $error("sav_vote needs 1 <= K <= N.");
        end
    endgenerate

    always_comb begin
        int unsigned cnt;
        cnt = 0;
        for (int i = 0; i < N; i++) begin
            cnt = cnt + 32'(trip[i]);
        end
        hit = (cnt >= 32'(K));
    end
endmodule

/* test/sav_top_props.sv */
// Port checker for the actuation voting block, bound to its top module.
// Assumes pins change just after rising edges of aclk.
`timescale 1ns/100ps
module sav_top_props
    import sav_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire sav_pkg::sav_chan_in_t chan_in,
    input wire sav_pkg::sav_train_in_t [1:0] train_in,
    input wire sav_pkg::sav_train_out_t [1:0] train_out,
    input wire logic [1:0] tank_alarm
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence hi_two_s;
        ($countones(~chan_in.hi_ok) >= 2)[*3];
    endsequence

    sequence hh_two_s;
        ($countones(chan_in.hh_trip & chan_in.hh_test_closed) >= 2)[*3];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    si_fanout_a: assert property (train_out[0][16:9] ==
        {8{train_out[0].master_si}}) else $error("injection fan-out split");
    cda_fanout_a: assert property (train_out[1][7:2] ==
        {6{train_out[1].master_cda}}) else $error("spray fan-out split");
    sli_fanout_a: assert property (train_out[0].steam_iso ==
        train_out[0].master_sli) else $error("isolation fan-out split");
    hi_vote_a: assert property (hi_two_s |=>
        train_out[0].master_si && train_out[1].master_si)
        else $error("high vote gave no injection");
    ihh_vote_a: assert property (($countones(~chan_in.ihh_ok) >= 2)[*3]
        |=> train_out[0].master_sli) else $error("no steam isolation");
    hh_vote_a: assert property (hh_two_s |=>
        train_out[1].master_cda && train_out[1].isol_phase_b)
        else $error("high-high vote gave no spray");
    manual_si_a: assert property ((|train_in[1].manual_si)[*3]
        |=> train_out[1].master_si) else $error("manual injection lost");
    si_hold_a: assert property ($rose(train_out[0].master_si) |=>
        train_out[0].master_si[*8]) else $error("injection dropped early");
    si_clear_a: assert property ($fell(train_out[0].master_si) |->
        $past(train_in[0].si_selector_normal_or_clear, 3) &&
        $past(train_in[0].breakers_open, 3)) else $error("bad clear");
    tank_a: assert property ((chan_in.tank_low[1:0] == 2'h3)[*3]
        |=> tank_alarm == 2'h3) else $error("tank alarm missing");
endmodule

bind sav_top sav_top_props u_props (
    .aclk(aclk),
    .aresetn(aresetn),
    .chan_in(chan_in),
    .train_in(train_in),
    .train_out(train_out),
    .tank_alarm(tank_alarm)
);

/* test/sav_plant.sv */
// Far-side model of the redundant pressure and process channels.
// Assumes trip requests are levels; the pins follow them directly.
`timescale 1ns/100ps
module sav_plant
    import sav_pkg::*;
(
    input wire logic [2:0] hi_trip,
    input wire logic [2:0] hi_open,
    input wire logic [2:0] ihh_trip,
    input wire logic [2:0] ihh_open,
    input wire logic [3:0] hh_over,
    input wire logic [3:0] hh_open,
    input wire logic [10:0] proc_trip,
    input wire logic [3:0] tank_low,
    output sav_pkg::sav_chan_in_t chan_in
);
    always_comb begin
        chan_in.hi_ok = ~hi_trip;
        chan_in.hi_test_closed = ~hi_open;
        chan_in.ihh_ok = ~ihh_trip;
        chan_in.ihh_test_closed = ~ihh_open;
        chan_in.hh_trip = hh_over;
        chan_in.hh_test_closed = ~hh_open;
        {chan_in.steam_flow_hi, chan_in.steam_press_lo, chan_in.tavg_lolo,
            chan_in.steam_dp_hi, chan_in.prz_press_lolo} = proc_trip;
        chan_in.tank_low = tank_low;
    end
endmodule

/* test/test_sav_top.sv */
// Self-checking bench for the actuation voting block.
// Assumes the channel model and the bound port checker.
`timescale 1ns/100ps
module test_sav_top;
    import sav_pkg::*;
    localparam logic [5:0] EXV [0:19] = '{6'h03, 6'h03, 6'h00, 6'h03,
        6'h03, 6'h03, 6'h03, 6'h00, 6'h00, 6'h01, 6'h02, 6'h0c, 6'h0c,
        6'h30, 6'h00, 6'h20, 6'h00, 6'h04, 6'h00, 6'h00};
    localparam logic [3:0] TKV [0:2] = '{4'h3, 4'h8, 4'hc};
    logic aclk, aresetn, chg, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [2:0] hi, hio, ih, iho;
    logic [3:0] hh, hho, tk, wstrb;
    logic [10:0] prc;
    logic [11:0] wide;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] talarm, bresp, rresp, rs;
    sav_chan_in_t cin;
    sav_train_in_t [1:0] tin;
    sav_train_out_t [1:0] tout;
    int fail_count, checks_done;

    sav_plant u_plant (.hi_trip(hi), .hi_open(hio), .ihh_trip(ih),
        .ihh_open(iho), .hh_over(hh), .hh_open(hho), .proc_trip(prc),
        .tank_low(tk), .chan_in(cin));
    sav_top #(.RESET_DELAY_CYCLES(32'h10)) DUT (.aclk(aclk),
        .aresetn(aresetn), .chan_in(cin), .train_in(tin),
        .wide_range_press(wide), .train_out(tout), .tank_alarm(talarm),
        .recirc_changeover(chg), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while ((awready !== 1'b1 || wready !== 1'b1) && n < 50);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            close_out();
        end
        @(posedge aclk);
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            close_out();
        end
        @(posedge aclk);
    endtask

    function automatic logic [17:0] oexp(input logic si, cda, sli);
        return {{9{si}}, {7{cda}}, {2{sli}}};
    endfunction

    task automatic tchk(input logic [5:0] x);
        chk("train0", 32'(oexp(x[0], x[4], x[2])), 32'(tout[0]));
        chk("train1", 32'(oexp(x[1], x[5], x[3])), 32'(tout[1]));
    endtask

    task automatic clr();
        tin <= 16'h0707;
        cyc(24);
        tin <= '0;
        cyc(4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    initial begin
        aresetn = 1'b0;
        {hi, hio, ih, iho, hh, hho, prc, tk, wide} = '0;
        tin = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        fail_count = 0;
        checks_done = 0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(2);
        tchk(6'h00);
        for (int k = 0; k < 20; k++) begin
            case (k)
                0: hi <= 3'h5;
                1: hio <= 3'h6;
                2: hi <= 3'h1;
                3: prc <= 11'h001;
                4: prc <= 11'h002;
                5: prc <= 11'h360;
                6: prc <= 11'h30c;
                7: prc <= 11'h300;
                8: prc <= 11'h160;
                9: tin[0].manual_si <= 2'h1;
                10: tin[1].manual_si <= 2'h2;
                11: ih <= 3'h3;
                12: iho <= 3'h5;
                13: hh <= 4'h9;
                14: {hh, hho} <= 8'h91;
                15: tin[1].manual_spray <= 2'h3;
                16: tin[0].manual_spray <= 2'h1;
                17: tin[0].manual_sli <= 1'b1;
                18: wide <= 12'hfff;
                default: hh <= 4'h1;
            endcase
            cyc(4);
            tchk(EXV[k]);
            {hi, hio, ih, iho, hh, hho, prc, wide} <= '0;
            clr();
            tchk(6'h00);
        end
        tin <= 16'h0505;
        hi <= 3'h5;
        cyc(4);
        tchk(6'h03);
        hi <= 3'h0;
        cyc(4);
        tchk(6'h03);
        cyc(20);
        tchk(6'h00);
        tin <= '0;
        hi <= 3'h5;
        cyc(4);
        hi <= 3'h0;
        tin <= 16'h0404;
        cyc(30);
        tchk(6'h03);
        tin <= 16'h0505;
        cyc(4);
        tchk(6'h00);
        tin <= '0;
        axr(SAV_OFS_CTRL, rd, rs);
        chk("ctrl reset", 32'h0, rd);
        axw(SAV_OFS_CTRL, 32'hffffffff, rs);
        chk("ctrl resp", 32'(SAV_RESP_OKAY), 32'(rs));
        axr(SAV_OFS_CTRL, rd, rs);
        chk("ctrl", 32'h3f, rd);
        cyc(2);
        tchk(6'h3f);
        axr(SAV_OFS_STATUS, rd, rs);
        chk("status", 32'h0000f8f8, rd);
        axr(SAV_OFS_TIMER0, rd, rs);
        chk("timer0", 32'h7, rd);
        axw(SAV_OFS_CTRL, 32'h0, rs);
        clr();
        tchk(6'h00);
        axw(SAV_OFS_STATUS, 32'hffffffff, rs);
        chk("ro resp", 32'(SAV_RESP_OKAY), 32'(rs));
        axw(8'h40, 32'h1, rs);
        chk("bad wr resp", 32'(SAV_RESP_SLVERR), 32'(rs));
        axr(8'h40, rd, rs);
        chk("bad rd resp", 32'(SAV_RESP_SLVERR), 32'(rs));
        chk("bad rd data", 32'h0, rd);
        wide <= 12'h5a5;
        cyc(3);
        axr(SAV_OFS_WIDE, rd, rs);
        chk("wide", 32'h5a5, rd);
        tchk(6'h00);
        for (int k = 0; k < 3; k++) begin
            tk <= TKV[k];
            cyc(4);
            chk("alarm", 32'(TKV[k][1:0]), 32'(talarm));
            chk("changeover", 32'($countones(TKV[k]) >= 2), 32'(chg));
        end
        aresetn <= 1'b0;
        cyc(3);
        aresetn <= 1'b1;
        cyc(1);
        tchk(6'h00);
        close_out();
    end
endmodule
